// ---- pstl_consts.vh ----
// Constants for the phase-selective trip logic block.
// Assumes a 50 MHz system clock and an APB register port.
//
// Overview of operation
// - Mode is off, three-phase only or mixed, off after reset.
// - Each trip command lasts at least the minimum pulse time unless block or off mode drops it.
// - Requests in two phases trip the third phase as well.
// - Any fault inside the evolving-fault window trips all phases.
// - Force-three-phase turns any single-phase trip into three-phase.
// - General trip is high whenever any trip command is high.
// - The block input holds all trip outputs low.
// - One request input and one trip output exist per phase.
// - The three-phase output is high when all phases trip.
// - Each on or off change of phase and general trips is an event.
// - In off mode no trip output is ever raised.

`ifndef PSTL_CONSTS_VH
`define PSTL_CONSTS_VH

// Time base
`define PSTL_CLK_HZ 50000000
`define PSTL_TICK_MS 1
`define PSTL_MS_CYCLES ((`PSTL_CLK_HZ / 1000) * `PSTL_TICK_MS)
`define PSTL_MS_CNT_W 17

// Register byte addresses
`define PSTL_ADDR_W 8
`define PSTL_ADDR_CTRL 8'h00
`define PSTL_ADDR_PULSE 8'h04
`define PSTL_ADDR_EVOLV 8'h08
`define PSTL_ADDR_STATE 8'h0c
`define PSTL_ADDR_EVSTAT 8'h10
`define PSTL_ADDR_EVEN 8'h14
`define PSTL_ADDR_EVCLR 8'h18

// Operating modes
`define PSTL_MODE_W 2
`define PSTL_MODE_OFF 2'h0
`define PSTL_MODE_3PH 2'h1
`define PSTL_MODE_MIX 2'h2

// Times in ms, range and defaults
`define PSTL_TIME_W 16
`define PSTL_TIME_MIN 16'h0032
`define PSTL_TIME_MAX 16'hea60
`define PSTL_PULSE_DEF 16'h0096
`define PSTL_EVOLV_DEF 16'h03e8

// Event layout: [3:0] on of L1,L2,L3,general, [7:4] off of same
`define PSTL_EV_W 8
`define PSTL_STATE_W 7

`endif

// ---- pstl_ms_tick.v ----
// Millisecond tick generator for the trip logic timers.
// Assumes one free-running system clock and a synchronous reset.
`timescale 1ns/100ps
`default_nettype none
`include "pstl_consts.vh"

module pstl_ms_tick
#(
  parameter MS_CYCLES = `PSTL_MS_CYCLES
)
(
  input wire clk_sys_in,
  input wire srst_in,
  output reg tick_out
);

  reg [`PSTL_MS_CNT_W-1:0] cnt_q;

  // Divide the clock down to one pulse per ms
  always @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      cnt_q <= {`PSTL_MS_CNT_W{1'b0}};
      tick_out <= 1'b0;
    end
    else if (cnt_q == MS_CYCLES[`PSTL_MS_CNT_W-1:0] - 1'b1)
    begin
      cnt_q <= {`PSTL_MS_CNT_W{1'b0}};
      tick_out <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      tick_out <= 1'b0;
    end
  end

endmodule // pstl_ms_tick
`default_nettype wire

// ---- pstl_ms_timer.v ----
// Retriggerable millisecond timer, busy while running.
// Assumes a one-cycle tick input at 1 ms spacing.
`timescale 1ns/100ps
`default_nettype none
`include "pstl_consts.vh"

module pstl_ms_timer
(
  input wire clk_sys_in,
  input wire srst_in,
  input wire tick_in,
  input wire start_in,
  input wire [`PSTL_TIME_W-1:0] len_in,
  output reg busy_out
);

  // One extra count covers the unknown phase of the first tick
  reg [`PSTL_TIME_W:0] cnt_q;

  // Load on start, count ticks down, drop busy at zero
  always @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      cnt_q <= {(`PSTL_TIME_W+1){1'b0}};
      busy_out <= 1'b0;
    end
    else if (start_in)
    begin
      cnt_q <= {1'b0, len_in} + 1'b1;
      busy_out <= 1'b1;
    end
    else if (busy_out && tick_in)
    begin
      cnt_q <= cnt_q - 1'b1;
      if (cnt_q == {{`PSTL_TIME_W{1'b0}}, 1'b1})
        busy_out <= 1'b0;
    end
  end

endmodule // pstl_ms_timer
`default_nettype wire

// ---- pstl_top.v ----
// Phase-selective trip logic with APB settings and event interrupt.
// Assumes requests are synchronous levels from protection logic and
// an APB master on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "pstl_consts.vh"

module pstl_top
#(
  parameter MS_CYCLES = `PSTL_MS_CYCLES
)
(
  input wire clk_sys_in,
  input wire srst_in,
  // APB slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [`PSTL_ADDR_W-1:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  // Trip requests
  input wire block_in,
  input wire single_phase_request_in,
  input wire three_phase_request_in,
  input wire phase1_request_in,
  input wire phase2_request_in,
  input wire phase3_request_in,
  input wire force_three_phase_in,
  // Trip commands and event interrupt
  output reg phase1_trip_out,
  output reg phase2_trip_out,
  output reg phase3_trip_out,
  output reg general_trip_out,
  output reg three_phase_trip_out,
  output reg irq_out
);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Force a written time into the legal range
  function [`PSTL_TIME_W-1:0] pstl_clamp;
    input [31:0] v;
    begin
      if (v < {16'h0000, `PSTL_TIME_MIN})
        pstl_clamp = `PSTL_TIME_MIN;
      else if (v > {16'h0000, `PSTL_TIME_MAX})
        pstl_clamp = `PSTL_TIME_MAX;
      else
        pstl_clamp = v[`PSTL_TIME_W-1:0];
    end
  endfunction

  // Word address match
  function pstl_hit;
    input [`PSTL_ADDR_W-1:0] a;
    input [`PSTL_ADDR_W-1:0] r;
    begin
      pstl_hit = (a == r);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  reg [`PSTL_MODE_W-1:0] mode_q;
  reg [`PSTL_TIME_W-1:0] pulse_len_q;
  reg [`PSTL_TIME_W-1:0] evolv_len_q;
  reg [`PSTL_EV_W-1:0] ev_stat_q;
  reg [`PSTL_EV_W-1:0] ev_en_q;
  reg [`PSTL_EV_W-1:0] ev_stat_d;
  reg [`PSTL_EV_W-1:0] ev_clr;
  reg [`PSTL_EV_W-1:0] ev_new;
  reg [2:0] cmd_d;
  reg [2:0] demand;
  reg [31:0] rd_d;
  reg rd_err;
  reg mode_off;
  reg want3;
  reg gen_d;
  wire [2:0] cmd_q;
  wire [2:0] phases;
  wire any_req;
  wire two_ph;
  wire wr_acc;
  wire tick;
  wire pulse_busy;
  wire evolv_busy;
  wire pulse_start;
  wire evolv_start;

  assign cmd_q = {phase3_trip_out, phase2_trip_out, phase1_trip_out};
  assign phases = {phase3_request_in, phase2_request_in,
                   phase1_request_in};

  ////////////////////////////////////////////////////////////////////////
  // Time base and timers

  pstl_ms_tick #(
    .MS_CYCLES(MS_CYCLES)
  ) u_tick (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .tick_out(tick)
  );

  pstl_ms_timer u_pulse (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .tick_in(tick),
    .start_in(pulse_start),
    .len_in(pulse_len_q),
    .busy_out(pulse_busy)
  );

  pstl_ms_timer u_evolv (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .tick_in(tick),
    .start_in(evolv_start),
    .len_in(evolv_len_q),
    .busy_out(evolv_busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decision logic

  // Request qualifiers
  assign any_req = (|phases) | single_phase_request_in;
  assign two_ph = (phases[0] & phases[1]) | (phases[0] & phases[2]) |
                  (phases[1] & phases[2]);

  // Mode decode, unused code behaves as off
  always @*
  begin
    mode_off = (mode_q != `PSTL_MODE_3PH) &&
               (mode_q != `PSTL_MODE_MIX);
  end

  // When to widen to three phases
  always @*
  begin
    want3 = three_phase_request_in;
    if (two_ph)
      want3 = 1'b1;
    if (force_three_phase_in && any_req)
      want3 = 1'b1;
    if (evolv_busy && (any_req || three_phase_request_in))
      want3 = 1'b1;
    if (mode_q == `PSTL_MODE_3PH && any_req)
      want3 = 1'b1;
  end

  // Per-phase demand, suppressed when off or blocked
  always @*
  begin
    if (mode_off || block_in)
      demand = 3'h0;
    else if (want3)
      demand = 3'h7;
    else
      demand = phases;
  end

  // Restart the pulse timer whenever a phase is newly added
  assign pulse_start = |(demand & ~cmd_q);

  // Hold commands until the pulse timer has run out
  always @*
  begin
    if (mode_off || block_in)
      cmd_d = 3'h0;
    else
      cmd_d = demand | (cmd_q & {3{pulse_busy}});
    gen_d = |cmd_d;
  end

  // Evolving window opens as a trip ends
  assign evolv_start = general_trip_out & ~gen_d;

  // Trip outputs from flops
  always @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      phase1_trip_out <= 1'b0;
      phase2_trip_out <= 1'b0;
      phase3_trip_out <= 1'b0;
      general_trip_out <= 1'b0;
      three_phase_trip_out <= 1'b0;
    end
    else
    begin
      phase1_trip_out <= cmd_d[0];
      phase2_trip_out <= cmd_d[1];
      phase3_trip_out <= cmd_d[2];
      general_trip_out <= gen_d;
      three_phase_trip_out <= &cmd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Events and interrupt

  // On and off edges of L1, L2, L3 and general
  always @*
  begin
    ev_new = {~{gen_d, cmd_d} & {general_trip_out, cmd_q},
              {gen_d, cmd_d} & ~{general_trip_out, cmd_q}};
  end

  assign wr_acc = psel_in & penable_in & pready_out & pwrite_in;

  // Clear mask from a write to the clear register
  always @*
  begin
    if (wr_acc && pstl_hit(paddr_in, `PSTL_ADDR_EVCLR))
      ev_clr = pwdata_in[`PSTL_EV_W-1:0];
    else
      ev_clr = {`PSTL_EV_W{1'b0}};
    ev_stat_d = (ev_stat_q & ~ev_clr) | ev_new; // Set beats clear
  end

  // Sticky status and level interrupt
  always @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      ev_stat_q <= {`PSTL_EV_W{1'b0}};
      irq_out <= 1'b0;
    end
    else
    begin
      ev_stat_q <= ev_stat_d;
      irq_out <= |(ev_stat_d & ev_en_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB registers

  // Settings writes take effect at the access edge
  always @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      mode_q <= `PSTL_MODE_OFF;
      pulse_len_q <= `PSTL_PULSE_DEF;
      evolv_len_q <= `PSTL_EVOLV_DEF;
      ev_en_q <= {`PSTL_EV_W{1'b0}};
    end
    else if (wr_acc)
    begin
      if (pstl_hit(paddr_in, `PSTL_ADDR_CTRL))
        mode_q <= pwdata_in[`PSTL_MODE_W-1:0];
      if (pstl_hit(paddr_in, `PSTL_ADDR_PULSE))
        pulse_len_q <= pstl_clamp(pwdata_in);
      if (pstl_hit(paddr_in, `PSTL_ADDR_EVOLV))
        evolv_len_q <= pstl_clamp(pwdata_in);
      if (pstl_hit(paddr_in, `PSTL_ADDR_EVEN))
        ev_en_q <= pwdata_in[`PSTL_EV_W-1:0];
    end
  end

  // Read data and error for the addressed word
  always @*
  begin
    rd_d = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr_in)
      `PSTL_ADDR_CTRL:
        rd_d[`PSTL_MODE_W-1:0] = mode_q;
      `PSTL_ADDR_PULSE:
        rd_d[`PSTL_TIME_W-1:0] = pulse_len_q;
      `PSTL_ADDR_EVOLV:
        rd_d[`PSTL_TIME_W-1:0] = evolv_len_q;
      `PSTL_ADDR_STATE:
        rd_d[`PSTL_STATE_W-1:0] = {evolv_busy, pulse_busy,
                                   three_phase_trip_out,
                                   general_trip_out, cmd_q};
      `PSTL_ADDR_EVSTAT:
        rd_d[`PSTL_EV_W-1:0] = ev_stat_q;
      `PSTL_ADDR_EVEN:
        rd_d[`PSTL_EV_W-1:0] = ev_en_q;
      `PSTL_ADDR_EVCLR:
        rd_d = 32'h0000_0000; // Write-only, reads zero
      default:
        rd_err = 1'b1;
    endcase
  end

  // Answer one cycle after setup, in the access phase
  always @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end
    else
    begin
      pready_out <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & rd_err;
      if (psel_in && !penable_in && !pwrite_in)
        prdata_out <= rd_d;
      else
        prdata_out <= 32'h0000_0000;
    end
  end

endmodule // pstl_top
`default_nettype wire

// ---- pstl_top_properties.sv ----
// Trip output checker, bound to the ports of pstl_top.
// Assumes pulse settings of 50 ms or more and no mode change mid-trip.
`timescale 1ns/100ps
`default_nettype none
module pstl_top_chk
#(
  parameter MS_CYCLES = 4
)
(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic block_in,
  input wire logic three_phase_request_in,
  input wire logic phase1_request_in,
  input wire logic phase2_request_in,
  input wire logic force_three_phase_in,
  input wire logic phase1_trip_out,
  input wire logic phase2_trip_out,
  input wire logic phase3_trip_out,
  input wire logic general_trip_out,
  input wire logic three_phase_trip_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  localparam int MIN_HOLD = 50 * MS_CYCLES - 4;
  logic [31:0] hold_q;
  wire any_w = phase1_trip_out | phase2_trip_out | phase3_trip_out;
  wire all_w = phase1_trip_out & phase2_trip_out & phase3_trip_out;
  // Cycles the general trip has been high
  always @(posedge clk_sys_in)
    hold_q <= general_trip_out ? hold_q + 32'h1 : 32'h0;
  // Trip ends on its own, not by blocking
  sequence s_trip_end;
    $fell(general_trip_out) ##0 !$past(block_in);
  endsequence
  a_general_is_or: assert property (
    general_trip_out == any_w) else $error("general trip mismatch");
  a_three_is_and: assert property (
    three_phase_trip_out == all_w) else $error("three-phase mismatch");
  a_block_drops: assert property (
    block_in |=> !any_w && !general_trip_out)
    else $error("trip while blocked");
  a_two_phase_third: assert property (
    !block_in && phase1_request_in && phase2_request_in |=> any_w |-> all_w)
    else $error("third phase missing");
  a_force_widens: assert property (
    !block_in && force_three_phase_in |=> any_w |-> all_w)
    else $error("forced trip not three-phase");
  a_three_request: assert property (
    !block_in && three_phase_request_in |=> any_w == all_w)
    else $error("three-phase request not widened");
  a_min_pulse: assert property (
    s_trip_end |-> hold_q >= MIN_HOLD) else $error("trip pulse too short");
  a_reset_idle: assert property (
    $fell(srst_in) |-> !general_trip_out && !three_phase_trip_out)
    else $error("trip active after reset");
endmodule // pstl_top_chk
bind pstl_top pstl_top_chk #(.MS_CYCLES(MS_CYCLES)) u_chk
(
  .clk_sys_in(clk_sys_in),
  .srst_in(srst_in),
  .block_in(block_in),
  .three_phase_request_in(three_phase_request_in),
  .phase1_request_in(phase1_request_in),
  .phase2_request_in(phase2_request_in),
  .force_three_phase_in(force_three_phase_in),
  .phase1_trip_out(phase1_trip_out),
  .phase2_trip_out(phase2_trip_out),
  .phase3_trip_out(phase3_trip_out),
  .general_trip_out(general_trip_out),
  .three_phase_trip_out(three_phase_trip_out)
);
`default_nettype wire

// ---- pstl_req_model.sv ----
// Request source standing in for the protection logic.
// Assumes the bench sets the wanted request word at clock edges.
`timescale 1ns/100ps
`default_nettype none
module pstl_req_model
(
  input wire logic clk_sys_in,
  input wire logic [6:0] want_in,
  output logic [6:0] req_out
);
  // Registered levels: block, 1ph, 3ph, L1, L2, L3, force
  always @(posedge clk_sys_in)
    req_out <= want_in;
endmodule // pstl_req_model
`default_nettype wire

// ---- pstl_top_tb.sv ----
// Self-checking bench for pstl_top: APB settings and trip scenarios.
// Assumes MS_CYCLES of 4, so 1 ms is 4 clock cycles.
`timescale 1ns/100ps
`default_nettype none
module pstl_top_tb_top;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, p1, p2, p3, gen, th, irq, err;
  logic [6:0] want = 7'h00;
  logic [6:0] req;
  logic [31:0] rd;
  int n_fail = 0;
  int tests_run = 0;
  int n;
  // 50 MHz clock
  always #10 clk_sys_in = ~clk_sys_in;
  pstl_req_model u_req (.clk_sys_in(clk_sys_in), .want_in(want),
    .req_out(req));
  pstl_top #(.MS_CYCLES(4)) dut (.clk_sys_in(clk_sys_in),
    .srst_in(srst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .block_in(req[6]), .single_phase_request_in(req[5]),
    .three_phase_request_in(req[4]), .phase1_request_in(req[3]),
    .phase2_request_in(req[2]), .phase3_request_in(req[1]),
    .force_three_phase_in(req[0]), .phase1_trip_out(p1),
    .phase2_trip_out(p2), .phase3_trip_out(p3), .general_trip_out(gen),
    .three_phase_trip_out(th), .irq_out(irq));
  task check(input logic [31:0] seen, input logic [31:0] exp);
  begin
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task step(input int c);
  begin
    repeat (c) @(posedge clk_sys_in);
    #1;
  end
  endtask
  // One APB transfer, waiting for pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    @(posedge clk_sys_in);
    while (pready !== 1'b1)
      @(posedge clk_sys_in);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  // One-cycle request, then outputs {L1,L2,L3,general,3ph}
  task trip(input logic [6:0] v, input logic [31:0] exp);
  begin
    @(posedge clk_sys_in);
    want <= v;
    @(posedge clk_sys_in);
    want <= 7'h00;
    step(2);
    check({27'h0, p1, p2, p3, gen, th}, exp);
  end
  endtask
  // Wait for the trip to end; 50 ms of 4-cycle ticks plus tick phase
  task drain;
  begin
    n = 0;
    while (gen === 1'b1 && n < 5000)
    begin
      step(1);
      n++;
    end
    check({31'h0, n >= 196 && n <= 212}, 32'h1);
  end
  endtask
  // Watchdog sized well above the whole sequence
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    n_fail++;
    report_and_stop;
  end
  initial
  begin
    repeat (5) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    apb(0, 8'h00, 0);
    check(rd, 32'h0);
    apb(0, 8'h04, 0);
    check(rd, 32'h96);
    apb(0, 8'h08, 0);
    check(rd, 32'h3e8);
    apb(0, 8'h1c, 0);
    check({31'h0, err}, 32'h1);
    trip(7'h08, 32'h00);
    $display("reset and off mode done");
    apb(1, 8'h04, 32'h32);
    apb(1, 8'h08, 32'h0a);
    apb(0, 8'h08, 0);
    check(rd, 32'h32);
    apb(1, 8'h14, 32'hff);
    apb(1, 8'h00, 32'h2);
    trip(7'h28, 32'h12);
    check({31'h0, irq}, 32'h1);
    drain;
    apb(0, 8'h10, 0);
    check(rd, 32'h99);
    apb(1, 8'h18, 32'hff);
    step(1);
    check({31'h0, irq}, 32'h0);
    $display("single phase done");
    trip(7'h04, 32'h1f);
    drain;
    step(300);
    trip(7'h0c, 32'h1f);
    drain;
    step(300);
    trip(7'h03, 32'h1f);
    drain;
    step(300);
    $display("widening done");
    trip(7'h10, 32'h1f);
    @(posedge clk_sys_in);
    want <= 7'h40;
    step(2);
    check({27'h0, p1, p2, p3, gen, th}, 32'h0);
    want <= 7'h00;
    step(500);
    $display("block done");
    apb(1, 8'h00, 32'h1);
    trip(7'h04, 32'h1f);
    drain;
    $display("three-phase mode done");
    // Reset in the middle of a trip drops it and turns the block off
    trip(7'h24, 32'h1f);
    @(posedge clk_sys_in);
    srst_in <= 1'b1;
    step(2);
    check({27'h0, p1, p2, p3, gen, th}, 32'h0);
    @(posedge clk_sys_in);
    srst_in <= 1'b0;
    apb(0, 8'h00, 0);
    check(rd, 32'h0);
    $display("mid-run reset done");
    report_and_stop;
  end
endmodule // pstl_top_tb_top
`default_nettype wire
